// [pkg/kpcfg_pkg.sv]
// Constants for the keypad pin configuration and interrupt enable bank.
// Assumes a 100 MHz core clock and an 8-bit internal register port.
package kpcfg_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_SCAN_TIMING = 8'h39;
    localparam logic [7:0] ADDR_ROW_PIN = 8'h3a;
    localparam logic [7:0] ADDR_COL_PIN = 8'h3b;
    localparam logic [7:0] ADDR_ALT_PIN = 8'h3c;
    localparam logic [7:0] ADDR_CORE_CFG = 8'h3d;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h3e;
    // Writable bit masks, reserved bits stay zero
    localparam logic [7:0] MASK_SCAN_TIMING = 8'h0b;
    localparam logic [7:0] MASK_ROW_PIN = 8'h3f;
    localparam logic [7:0] MASK_COL_PIN = 8'h1f;
    localparam logic [7:0] MASK_ALT_PIN = 8'hf9;
    localparam logic [7:0] MASK_CORE_CFG = 8'he7;
    localparam logic [7:0] MASK_IRQ_EN = 8'h17;
    // Reset values
    localparam logic [7:0] RST_VALUE = 8'h00;
    // Field positions
    localparam int PRECHARGE_BIT = 3;
    localparam int POLL_LSB = 0;
    localparam int PULL_SEL_BIT = 7;
    localparam int COL0_ALT_BIT = 6;
    localparam int ROW4_ALT_BIT = 5;
    localparam int COL1_ALT_BIT = 4;
    localparam int ROW3_ALT_BIT = 3;
    localparam int ROW0_ALT_BIT = 0;
    localparam int OSC_RUN_BIT = 7;
    localparam int DIV_LSB = 5;
    localparam int SOFTWARE_RESET_TRIGGER_BIT = 2;
    localparam int INT_CFG_BIT = 1;
    localparam int RST_CFG_BIT = 0;
    localparam int ROWS = 6;
    localparam int COLS = 5;
    localparam int FLAGS = 5;
    // Times and derived cycle counts
    localparam int CLK_MHZ = 100;
    localparam int PRECHARGE_SHORT_US = 100;
    localparam int PRECHARGE_LONG_US = 200;
    localparam int POLL_STEP_MS = 10;
    localparam int INT_GAP_US = 50;
    localparam int SOFTWARE_RESET_TRIGGER_PULSE_CYC = 2;
    localparam int INT_GAP_CYC = INT_GAP_US * CLK_MHZ;
    localparam int PRECHARGE_SHORT_CYC = PRECHARGE_SHORT_US * CLK_MHZ;
    localparam int PRECHARGE_LONG_CYC = PRECHARGE_LONG_US * CLK_MHZ;
    localparam int POLL_STEP_CYC = POLL_STEP_MS * 1000 * CLK_MHZ;
    // Core clock division from the 800 kHz oscillator
    localparam logic [3:0] DIV_50K = 4'h0;
    localparam logic [3:0] DIV_100K = 4'h1;
    localparam logic [3:0] DIV_200K = 4'h2;
    localparam logic [3:0] DIV_400K = 4'h3;
    localparam logic [4:0] DIV_RATIO_50K = 5'h10;
    localparam logic [4:0] DIV_RATIO_100K = 5'h08;
    localparam logic [4:0] DIV_RATIO_200K = 5'h04;
    localparam logic [4:0] DIV_RATIO_400K = 5'h02;
endpackage

// [src/kpcfg_bank.sv]
// Configuration register bank for keypad scan, pin function, core clock,
// reset and interrupt pin control.
// Assumes the serial interface decodes writes and reads into one-cycle
// strobes with an 8-bit address, and that all inputs share CLK.
`timescale 1ns/1ps

module kpcfg_bank (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic CLK_EN,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    output logic REG_HIT,
    input wire logic [4:0] STATUS_FLAGS,
    input wire logic IRQ_CLEAR,
    output logic INT_N,
    output logic RESET_PIN_EFFECTIVE_N,
    output logic CORE_RESET_N,
    output logic [31:0] PRECHARGE_CYCLES,
    output logic [31:0] POLL_CYCLES,
    output logic [5:0] ROW_IS_KEYPAD,
    output logic [4:0] COL_IS_KEYPAD,
    output logic ROW_PULLUP_STRONG,
    output logic OSCILLATOR_RUN,
    output logic [4:0] CORE_CLOCK_RATIO,
    input wire logic PULSER_ONE_OUT,
    input wire logic PULSER_TWO_OUT,
    input wire logic RESET_GEN_OUT,
    input wire logic LOGIC_BLOCK_RESULT,
    input wire logic [5:0] ROW_GPIO_OUT,
    input wire logic [4:0] COL_GPIO_OUT,
    input wire logic [5:0] ROW_PIN_IN,
    output logic [5:0] ROW_PIN_OUT,
    output logic [4:0] COL_PIN_OUT,
    output logic ROW0_ALT_ACTIVE,
    output logic ROW3_ALT_ACTIVE,
    output logic ROW4_ALT_ACTIVE,
    output logic COL0_ALT_ACTIVE,
    output logic COL1_ALT_ACTIVE,
    output logic LOGIC_THIRD_INPUT
);

    typedef struct packed {
        logic [7:0] scan_timing_config_r;
        logic [7:0] row_pin_function_r;
        logic [7:0] column_pin_function_r;
        logic [7:0] alternate_pin_function_r;
        logic [7:0] core_clock_reset_config_r;
        logic [7:0] interrupt_enable_r;
        logic [7:0] rdata_r;
        logic [1:0] swrst_cnt_r;
        logic [12:0] gap_cnt_r;
        logic gap_r;
    } kpcfg_state_t;

    kpcfg_state_t st_r;
    kpcfg_state_t st_nxt;
    logic hw_reset_n;
    logic irq_level;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic logic kpcfg_hit(input logic [7:0] a);
        kpcfg_hit = (a >= kpcfg_pkg::ADDR_SCAN_TIMING) &&
                    (a <= kpcfg_pkg::ADDR_IRQ_EN);
    endfunction

    function automatic logic [7:0] kpcfg_read(input kpcfg_state_t s,
                                              input logic [7:0] a);
        case (a)
            kpcfg_pkg::ADDR_SCAN_TIMING: kpcfg_read = s.scan_timing_config_r;
            kpcfg_pkg::ADDR_ROW_PIN: kpcfg_read = s.row_pin_function_r;
            kpcfg_pkg::ADDR_COL_PIN: kpcfg_read = s.column_pin_function_r;
            kpcfg_pkg::ADDR_ALT_PIN: kpcfg_read = s.alternate_pin_function_r;
            kpcfg_pkg::ADDR_CORE_CFG:
                kpcfg_read = s.core_clock_reset_config_r;
            kpcfg_pkg::ADDR_IRQ_EN: kpcfg_read = s.interrupt_enable_r;
            default: kpcfg_read = kpcfg_pkg::RST_VALUE;
        endcase
    endfunction

    // Reset pin honoured unless the reset config bit masks it
    assign hw_reset_n = RESET_N | st_r.core_clock_reset_config_r[
        kpcfg_pkg::RST_CFG_BIT];
    assign RESET_PIN_EFFECTIVE_N = hw_reset_n;
    assign CORE_RESET_N = hw_reset_n && (st_r.swrst_cnt_r == 2'h0);

    // Enabled flags ORed onto the interrupt line
    assign irq_level = |(STATUS_FLAGS &
                         st_r.interrupt_enable_r[kpcfg_pkg::FLAGS-1:0]);
    assign INT_N = ~(irq_level && !st_r.gap_r);

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.rdata_r = st_r.rdata_r;
        if (REG_RD) begin
            st_nxt.rdata_r = kpcfg_read(st_r, REG_ADDR);
        end
        // Register writes, reserved bits masked off
        if (REG_WR) begin
            case (REG_ADDR)
                kpcfg_pkg::ADDR_SCAN_TIMING: st_nxt.scan_timing_config_r =
                    REG_WDATA & kpcfg_pkg::MASK_SCAN_TIMING;
                kpcfg_pkg::ADDR_ROW_PIN: st_nxt.row_pin_function_r =
                    REG_WDATA & kpcfg_pkg::MASK_ROW_PIN;
                kpcfg_pkg::ADDR_COL_PIN: st_nxt.column_pin_function_r =
                    REG_WDATA & kpcfg_pkg::MASK_COL_PIN;
                kpcfg_pkg::ADDR_ALT_PIN: st_nxt.alternate_pin_function_r =
                    REG_WDATA & kpcfg_pkg::MASK_ALT_PIN;
                kpcfg_pkg::ADDR_CORE_CFG: begin
                    st_nxt.core_clock_reset_config_r = REG_WDATA &
                        kpcfg_pkg::MASK_CORE_CFG &
                        ~(8'h01 << kpcfg_pkg::SOFTWARE_RESET_TRIGGER_BIT);
                    if (REG_WDATA[kpcfg_pkg::SOFTWARE_RESET_TRIGGER_BIT]) begin
                        st_nxt.swrst_cnt_r =
                            2'(kpcfg_pkg::SOFTWARE_RESET_TRIGGER_PULSE_CYC);
                    end
                end
                kpcfg_pkg::ADDR_IRQ_EN: st_nxt.interrupt_enable_r =
                    REG_WDATA & kpcfg_pkg::MASK_IRQ_EN;
                default: begin
                end
            endcase
        end
        // Software reset pulse, every register at reset value from its second cycle on
        if (st_r.swrst_cnt_r != 2'h0) begin
            st_nxt = '0;
            st_nxt.swrst_cnt_r = st_r.swrst_cnt_r - 2'h1;
        end
        // Gap on interrupt clear while another is pending
        if (st_r.gap_r) begin
            if (st_r.gap_cnt_r == 13'h0001) begin
                st_nxt.gap_r = 1'b0;
                st_nxt.gap_cnt_r = 13'h0000;
            end else begin
                st_nxt.gap_cnt_r = st_r.gap_cnt_r - 13'h0001;
            end
        end else if (IRQ_CLEAR && irq_level &&
                     st_r.core_clock_reset_config_r[
                         kpcfg_pkg::INT_CFG_BIT]) begin
            st_nxt.gap_r = 1'b1;
            st_nxt.gap_cnt_r = 13'(kpcfg_pkg::INT_GAP_CYC);
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge hw_reset_n) begin
        if (!hw_reset_n) begin
            st_r <= '0;
        end else if (CLK_EN) begin
            st_r <= st_nxt;
        end
    end

    assign REG_RDATA = st_r.rdata_r;
    assign REG_HIT = kpcfg_hit(REG_ADDR);

    // ------------------------------------------------------------
    // Scan timing
    // ------------------------------------------------------------
    // Precharge and poll interval in core cycles
    always_comb begin
        if (st_r.scan_timing_config_r[kpcfg_pkg::PRECHARGE_BIT]) begin
            PRECHARGE_CYCLES = 32'(kpcfg_pkg::PRECHARGE_LONG_CYC);
        end else begin
            PRECHARGE_CYCLES = 32'(kpcfg_pkg::PRECHARGE_SHORT_CYC);
        end
        POLL_CYCLES = 32'(kpcfg_pkg::POLL_STEP_CYC) *
            (32'(st_r.scan_timing_config_r[kpcfg_pkg::POLL_LSB +: 2]) +
             32'h1);
    end

    // ------------------------------------------------------------
    // Oscillator and core clock
    // ------------------------------------------------------------
    always_comb begin
        OSCILLATOR_RUN =
            st_r.core_clock_reset_config_r[kpcfg_pkg::OSC_RUN_BIT];
        case ({2'h0, st_r.core_clock_reset_config_r[kpcfg_pkg::DIV_LSB +: 2]})
            kpcfg_pkg::DIV_50K: CORE_CLOCK_RATIO = kpcfg_pkg::DIV_RATIO_50K;
            kpcfg_pkg::DIV_100K: CORE_CLOCK_RATIO = kpcfg_pkg::DIV_RATIO_100K;
            kpcfg_pkg::DIV_200K: CORE_CLOCK_RATIO = kpcfg_pkg::DIV_RATIO_200K;
            kpcfg_pkg::DIV_400K: CORE_CLOCK_RATIO = kpcfg_pkg::DIV_RATIO_400K;
            default: CORE_CLOCK_RATIO = kpcfg_pkg::DIV_RATIO_50K;
        endcase
    end

    // ------------------------------------------------------------
    // Pin function
    // ------------------------------------------------------------
    assign ROW_IS_KEYPAD = st_r.row_pin_function_r[kpcfg_pkg::ROWS-1:0];
    assign COL_IS_KEYPAD = st_r.column_pin_function_r[kpcfg_pkg::COLS-1:0];
    assign ROW_PULLUP_STRONG =
        st_r.alternate_pin_function_r[kpcfg_pkg::PULL_SEL_BIT];

    // Alternate functions only while the pin is in GPIO mode
    assign COL0_ALT_ACTIVE = !COL_IS_KEYPAD[0] &&
        st_r.alternate_pin_function_r[kpcfg_pkg::COL0_ALT_BIT];
    assign ROW4_ALT_ACTIVE = !ROW_IS_KEYPAD[4] &&
        st_r.alternate_pin_function_r[kpcfg_pkg::ROW4_ALT_BIT];
    assign COL1_ALT_ACTIVE = !COL_IS_KEYPAD[1] &&
        st_r.alternate_pin_function_r[kpcfg_pkg::COL1_ALT_BIT];
    assign ROW3_ALT_ACTIVE = !ROW_IS_KEYPAD[3] &&
        st_r.alternate_pin_function_r[kpcfg_pkg::ROW3_ALT_BIT];
    assign ROW0_ALT_ACTIVE = !ROW_IS_KEYPAD[0] &&
        st_r.alternate_pin_function_r[kpcfg_pkg::ROW0_ALT_BIT];

    assign LOGIC_THIRD_INPUT = ROW3_ALT_ACTIVE & ROW_PIN_IN[3];

    // Output multiplexers for rows and columns
    always_comb begin
        ROW_PIN_OUT = ROW_GPIO_OUT;
        COL_PIN_OUT = COL_GPIO_OUT;
        if (ROW0_ALT_ACTIVE) begin
            ROW_PIN_OUT[0] = LOGIC_BLOCK_RESULT;
        end
        if (ROW4_ALT_ACTIVE) begin
            ROW_PIN_OUT[4] = RESET_GEN_OUT;
        end
        if (COL0_ALT_ACTIVE) begin
            COL_PIN_OUT[0] = PULSER_ONE_OUT;
        end
        if (COL1_ALT_ACTIVE) begin
            COL_PIN_OUT[1] = PULSER_TWO_OUT;
        end
    end

endmodule

// [test/kpcfg_bank_props.sv]
// Port checker for the keypad configuration bank.
// Assumes one clock domain; bound to the bank from the bench top file.
`timescale 1ns/1ps
module kpcfg_bank_props (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic CLK_EN,
    input wire logic REG_WR,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic [4:0] STATUS_FLAGS,
    input wire logic INT_N,
    input wire logic CORE_RESET_N,
    input wire logic [31:0] PRECHARGE_CYCLES,
    input wire logic [31:0] POLL_CYCLES,
    input wire logic [5:0] ROW_IS_KEYPAD,
    input wire logic [5:0] ROW_PIN_OUT,
    input wire logic [4:0] COL_PIN_OUT,
    input wire logic LOGIC_BLOCK_RESULT,
    input wire logic PULSER_ONE_OUT,
    input wire logic RESET_GEN_OUT,
    input wire logic ROW0_ALT_ACTIVE,
    input wire logic ROW4_ALT_ACTIVE,
    input wire logic COL0_ALT_ACTIVE
);
    logic wr_ok, wr39, wr3a, wr3d;
    // Accepted register writes
    assign wr_ok = REG_WR && CLK_EN && CORE_RESET_N;
    assign wr39 = wr_ok && REG_ADDR == 8'h39;
    assign wr3a = wr_ok && REG_ADDR == 8'h3a;
    assign wr3d = wr_ok && REG_ADDR == 8'h3d;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    // Software reset: two cycles of core reset, then a cleared bank
    sequence s_rst_hold;
        !CORE_RESET_N [*2];
    endsequence
    sequence s_rst_done;
        CORE_RESET_N && ROW_IS_KEYPAD == 6'h00;
    endsequence
    a_pre_time: assert property (
        wr39 |=> PRECHARGE_CYCLES ==
            ($past(REG_WDATA[3]) ? 32'd20000 : 32'd10000))
        else $error("precharge count wrong");
    a_poll_time: assert property (
        wr39 |=> POLL_CYCLES ==
            32'd1000000 * ({30'h0, $past(REG_WDATA[1:0])} + 32'd1))
        else $error("poll count wrong");
    a_row_select: assert property (
        wr3a |=> ROW_IS_KEYPAD == $past(REG_WDATA[5:0]))
        else $error("row select wrong");
    a_software_reset_trigger: assert property (
        wr3d && REG_WDATA[2] |=> s_rst_hold ##1 s_rst_done)
        else $error("software reset wrong");
    a_int_idle: assert property (
        STATUS_FLAGS == 5'h00 |-> INT_N)
        else $error("interrupt without flag");
    a_row0_mux: assert property (
        ROW0_ALT_ACTIVE |-> ROW_PIN_OUT[0] == LOGIC_BLOCK_RESULT
            && !ROW_IS_KEYPAD[0])
        else $error("row0 mux wrong");
    a_col0_mux: assert property (
        COL0_ALT_ACTIVE |-> COL_PIN_OUT[0] == PULSER_ONE_OUT)
        else $error("col0 mux wrong");
    a_row4_mux: assert property (
        ROW4_ALT_ACTIVE |-> ROW_PIN_OUT[4] == RESET_GEN_OUT
            && !ROW_IS_KEYPAD[4])
        else $error("row4 mux wrong");
endmodule

// [test/kpcfg_far_model.sv]
// Far-side pin model: pulsers, reset and logic outputs, pin levels.
// Assumes the bench clock; outputs change on its falling edge.
`timescale 1ns/1ps
module kpcfg_far_model (
    input wire logic CLK,
    output logic PULSER_ONE_OUT,
    output logic PULSER_TWO_OUT,
    output logic RESET_GEN_OUT,
    output logic LOGIC_BLOCK_RESULT,
    output logic [5:0] ROW_GPIO_OUT,
    output logic [4:0] COL_GPIO_OUT,
    output logic [5:0] ROW_PIN_IN
);
    logic [15:0] lfsr_r = 16'hace1;
    // Pattern changing every cycle, so a stuck mux shows up
    always @(negedge CLK) begin
        lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12]
            ^ lfsr_r[10]};
    end
    assign {PULSER_ONE_OUT, PULSER_TWO_OUT} = lfsr_r[1:0];
    assign {RESET_GEN_OUT, LOGIC_BLOCK_RESULT} = lfsr_r[3:2];
    assign ROW_GPIO_OUT = lfsr_r[9:4];
    assign COL_GPIO_OUT = lfsr_r[14:10];
    assign ROW_PIN_IN = lfsr_r[15:10];
endmodule

// [test/kpcfg_bank_test.sv]
// Self-checking bench for the keypad configuration bank.
// Assumes the far-side model and the bound port checker.
`timescale 1ns/1ps
module kpcfg_bank_test;
    logic CLK, RESET_N, CLK_EN, REG_WR, REG_RD, IRQ_CLEAR, INT_N, REG_HIT;
    logic RESET_PIN_EFFECTIVE_N, CORE_RESET_N, ROW_PULLUP_STRONG;
    logic OSCILLATOR_RUN, PULSER_ONE_OUT, PULSER_TWO_OUT, RESET_GEN_OUT;
    logic LOGIC_BLOCK_RESULT, ROW0_ALT_ACTIVE, ROW3_ALT_ACTIVE;
    logic ROW4_ALT_ACTIVE, COL0_ALT_ACTIVE, COL1_ALT_ACTIVE;
    logic LOGIC_THIRD_INPUT;
    logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA, d;
    logic [31:0] PRECHARGE_CYCLES, POLL_CYCLES;
    logic [31:0] seed = 32'ha7618c15;
    logic [5:0] ROW_IS_KEYPAD, ROW_GPIO_OUT, ROW_PIN_IN, ROW_PIN_OUT;
    logic [4:0] STATUS_FLAGS, COL_IS_KEYPAD, CORE_CLOCK_RATIO;
    logic [4:0] COL_GPIO_OUT, COL_PIN_OUT;
    logic [7:0] expq [$];
    logic [7:0] msk [6] = '{8'h0b, 8'h3f, 8'h1f, 8'hf9, 8'he3, 8'h17};
    int err_count = 0, n_tests = 0, i, n;
    kpcfg_bank kpcfg_bank_i (.CLK, .RESET_N, .CLK_EN, .REG_WR, .REG_RD,
        .REG_ADDR, .REG_WDATA, .REG_RDATA, .REG_HIT, .STATUS_FLAGS,
        .IRQ_CLEAR, .INT_N, .RESET_PIN_EFFECTIVE_N, .CORE_RESET_N,
        .PRECHARGE_CYCLES, .POLL_CYCLES, .ROW_IS_KEYPAD, .COL_IS_KEYPAD,
        .ROW_PULLUP_STRONG, .OSCILLATOR_RUN, .CORE_CLOCK_RATIO,
        .PULSER_ONE_OUT, .PULSER_TWO_OUT, .RESET_GEN_OUT,
        .LOGIC_BLOCK_RESULT, .ROW_GPIO_OUT, .COL_GPIO_OUT, .ROW_PIN_IN,
        .ROW_PIN_OUT, .COL_PIN_OUT, .ROW0_ALT_ACTIVE, .ROW3_ALT_ACTIVE,
        .ROW4_ALT_ACTIVE, .COL0_ALT_ACTIVE, .COL1_ALT_ACTIVE,
        .LOGIC_THIRD_INPUT);
    kpcfg_far_model kpcfg_far_model_i (.CLK, .PULSER_ONE_OUT,
        .PULSER_TWO_OUT, .RESET_GEN_OUT, .LOGIC_BLOCK_RESULT,
        .ROW_GPIO_OUT, .COL_GPIO_OUT, .ROW_PIN_IN);
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge CLK);
        {REG_WR, REG_ADDR, REG_WDATA} = {1'b1, a, v};
        @(negedge CLK);
        REG_WR = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge CLK);
        {REG_RD, REG_ADDR} = {1'b1, a};
        expq.push_back(e);
        @(negedge CLK);
        REG_RD = 1'b0;
    endtask
    task automatic clr();
        @(negedge CLK);
        IRQ_CLEAR = 1'b1;
        @(negedge CLK);
        IRQ_CLEAR = 1'b0;
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Clock and hang guard
    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end
    initial begin
        repeat (100000) @(posedge CLK);
        err_count++;
        stop_test();
    end
    // Read data lands on the edge that samples the read; checked at the next falling edge
    initial forever begin
        @(posedge CLK);
        if (REG_RD === 1'b1) begin
            @(negedge CLK);
            chk(REG_RDATA, expq.pop_front());
        end
    end
    // Main sequence
    initial begin
        {RESET_N, REG_WR, REG_RD, IRQ_CLEAR, CLK_EN} = 5'h01;
        {REG_ADDR, REG_WDATA, STATUS_FLAGS} = 21'h0;
        repeat (4) @(negedge CLK);
        RESET_N = 1'b1;
        for (i = 0; i < 8; i++) begin
            rd(8'h38 + i, 8'h00);
            chk(REG_HIT, i > 0 && i < 7);
        end
        for (i = 0; i < 24; i++) begin
            d = xs();
            if (i / 4 == 4) d[2] = 1'b0;
            wr(8'h39 + i / 4, d);
            rd(8'h39 + i / 4, d & msk[i / 4]);
        end
        $display("test registers done");
        for (i = 0; i < 4; i++) begin
            wr(8'h39, {4'h0, i[0], 1'b0, i[1:0]});
            wr(8'h3d, {1'b1, i[1:0], 5'h00});
            chk(POLL_CYCLES, 32'd1000000 * (i + 1));
            chk(PRECHARGE_CYCLES, i[0] ? 20000 : 10000);
            chk(CORE_CLOCK_RATIO, 5'h10 >> i);
            chk(OSCILLATOR_RUN, 1'b1);
        end
        wr(8'h3a, 8'h2a);
        wr(8'h3b, 8'h15);
        wr(8'h3c, 8'h80);
        chk(ROW_IS_KEYPAD, 6'h2a);
        chk(COL_IS_KEYPAD, 5'h15);
        chk(ROW_PULLUP_STRONG, 1'b1);
        // Clock enable low freezes the bank against a write
        CLK_EN = 1'b0;
        wr(8'h3a, 8'h01);
        chk(ROW_IS_KEYPAD, 6'h2a);
        CLK_EN = 1'b1;
        $display("test fields done");
        wr(8'h3a, 8'h00);
        wr(8'h3b, 8'h00);
        wr(8'h3c, 8'h79);
        repeat (8) begin
            @(negedge CLK);
            #1;
            chk(ROW_PIN_OUT[0], LOGIC_BLOCK_RESULT);
            chk(ROW_PIN_OUT[4], RESET_GEN_OUT);
            chk(COL_PIN_OUT[1:0], {PULSER_TWO_OUT, PULSER_ONE_OUT});
            chk(LOGIC_THIRD_INPUT, ROW_PIN_IN[3]);
            chk(ROW_PIN_OUT[2], ROW_GPIO_OUT[2]);
        end
        wr(8'h3a, 8'h19);
        wr(8'h3b, 8'h03);
        chk({ROW0_ALT_ACTIVE, ROW3_ALT_ACTIVE, ROW4_ALT_ACTIVE,
            COL0_ALT_ACTIVE, COL1_ALT_ACTIVE}, 5'h00);
        wr(8'h3b, 8'h00);
        wr(8'h3c, 8'h00);
        #1;
        chk(COL_PIN_OUT[0], COL_GPIO_OUT[0]);
        $display("test pins done");
        wr(8'h3d, 8'h00);
        chk(OSCILLATOR_RUN, 1'b0);
        wr(8'h3e, 8'h17);
        for (i = 0; i < 5; i++) begin
            @(negedge CLK);
            STATUS_FLAGS = 5'h01 << i;
            #1;
            chk(INT_N, i == 3);
        end
        STATUS_FLAGS = 5'h1f;
        wr(8'h3e, 8'h08);
        chk(INT_N, 1'b1);
        wr(8'h3e, 8'h01);
        clr();
        repeat (2) @(negedge CLK);
        chk(INT_N, 1'b0);
        wr(8'h3d, 8'h02);
        clr();
        chk(INT_N, 1'b1);
        for (n = 0; n < 6000 && INT_N !== 1'b0; n++) @(negedge CLK);
        if (n == 6000) begin
            err_count++;
            stop_test();
        end
        chk(n >= kpcfg_pkg::INT_GAP_CYC - 2
            && n <= kpcfg_pkg::INT_GAP_CYC + 1, 1);
        STATUS_FLAGS = 5'h00;
        $display("test interrupt done");
        wr(8'h3a, 8'h3f);
        wr(8'h3d, 8'h04);
        repeat (20000) @(negedge CLK);
        rd(8'h3a, 8'h00);
        rd(8'h3d, 8'h00);
        wr(8'h3d, 8'h01);
        RESET_N = 1'b0;
        #1;
        chk(RESET_PIN_EFFECTIVE_N, 1'b1);
        @(negedge CLK);
        RESET_N = 1'b1;
        rd(8'h3d, 8'h01);
        wr(8'h3d, 8'h00);
        wr(8'h3a, 8'h01);
        RESET_N = 1'b0;
        @(negedge CLK);
        RESET_N = 1'b1;
        rd(8'h3a, 8'h00);
        repeat (2) @(negedge CLK);
        $display("test reset done");
        stop_test();
    end
endmodule
bind kpcfg_bank kpcfg_bank_props kpcfg_bank_props_i (.CLK, .RESET_N,
    .CLK_EN, .REG_WR, .REG_ADDR, .REG_WDATA, .STATUS_FLAGS, .INT_N,
    .CORE_RESET_N, .PRECHARGE_CYCLES, .POLL_CYCLES, .ROW_IS_KEYPAD,
    .ROW_PIN_OUT, .COL_PIN_OUT, .LOGIC_BLOCK_RESULT, .PULSER_ONE_OUT,
    .RESET_GEN_OUT, .ROW0_ALT_ACTIVE, .ROW4_ALT_ACTIVE, .COL0_ALT_ACTIVE);
